// >>> hdl/amem_pkg.sv
// constants, field layouts and carrier types for the asynchronous memory interface
// assumes one clock, mclk, taken as the pll output; phases count a quarter-rate enable
package amem_pkg;
   // peripheral phase clock is a quarter of mclk
   localparam logic [1:0] TICK_LAST          = 2'h3;
   // one counted external wait cycle is sixteen phase periods
   localparam logic [3:0] WAIT_UNIT_LAST     = 4'hF;
   // strobe rises this many phase periods after the wait input drops
   localparam logic [3:0] WAIT_RELEASE_TICKS = 4'h4;
   localparam logic [3:0] WAIT_CHECK_TICK    = WAIT_UNIT_LAST - WAIT_RELEASE_TICKS;
   localparam logic [3:0] BURST_LEN_RESET    = 4'h0;
   localparam logic [9:0] ECC_POLY0          = 10'h009;
   localparam logic [9:0] ECC_POLY1          = 10'h01B;
   localparam logic [9:0] ECC_POLY2          = 10'h027;
   localparam logic [9:0] ECC_POLY3          = 10'h05D;

   // every field holds the length minus one
   typedef struct packed {
      logic [1:0] turnaround_cycles;
      logic [3:0] read_setup_cycles;
      logic [5:0] read_strobe_cycles;
      logic [2:0] read_hold_cycles;
      logic [3:0] write_setup_cycles;
      logic [5:0] write_strobe_cycles;
      logic [2:0] write_hold_cycles;
   } timing_t;

   typedef struct packed {
      logic        bus_16bit;
      logic        select_strobe_mode;
      logic        extended_wait_enable;
      logic        nand_mode;
      logic        burst_nand_mode;
      logic [7:0]  maximum_wait_cycles;  // count minus one
   } mode_t;

   typedef struct packed {
      logic        write;
      logic        cs;
      logic        burst;
      logic [3:0]  burst_len;            // words minus one
      logic [15:0] addr;
      logic [15:0] wdata;
   } request_t;

   typedef enum logic [6:0] {
      ST_IDLE   = 7'b000_0001,
      ST_SETUP  = 7'b000_0010,
      ST_STROBE = 7'b000_0100,
      ST_WAIT   = 7'b000_1000,
      ST_HOLD   = 7'b001_0000,
      ST_TURN   = 7'b010_0000,
      ST_BURST  = 7'b100_0000
   } state_t;
endpackage : amem_pkg

// >>> hdl/amem_ecc.sv
// nand error-correction accumulator: column parity and four 10-bit syndromes
// assumes valid is a one-cycle pulse per transferred word, on mclk
`timescale 1ns/10ps
module amem_ecc (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        clear,
   input  wire logic        valid,
   input  wire logic [15:0] data,
   output logic      [15:0] ecc1_reg,
   output logic      [39:0] ecc4_reg
);
   localparam logic [39:0] POLYS = {amem_pkg::ECC_POLY3, amem_pkg::ECC_POLY2,
                                    amem_pkg::ECC_POLY1, amem_pkg::ECC_POLY0};
   logic [9:0] fold;
   assign fold = data[9:0] ^ {4'h0, data[15:10]};

   always_ff @(posedge mclk) begin
      if (rst || clear) begin
         ecc1_reg <= 16'h0000;
      end else if (valid) begin
         ecc1_reg <= ecc1_reg ^ data;
      end
   end

   for (genvar i = 0; i < 4; i++) begin : g_syn
      always_ff @(posedge mclk) begin
         if (rst || clear) begin
            ecc4_reg[i*10 +: 10] <= 10'h000;
         end else if (valid) begin
            ecc4_reg[i*10 +: 10] <= {ecc4_reg[i*10 +: 9], 1'b0} ^ fold
                                    ^ (ecc4_reg[i*10+9] ? POLYS[i*10 +: 10] : 10'h000);
         end
      end
   end
endmodule : amem_ecc

// >>> hdl/amem_ctrl.sv
// asynchronous external memory controller: sram, nand and burst nand
// assumes mclk is the pll output, memory pins are asynchronous to it
`timescale 1ns/10ps
module amem_ctrl (
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                req_valid,
   input  wire amem_pkg::request_t  req,
   input  wire amem_pkg::timing_t   timing_cs0,
   input  wire amem_pkg::timing_t   timing_cs1,
   input  wire amem_pkg::mode_t     mode,
   input  wire logic                ecc_clear,
   input  wire logic                ext_wait_in,
   input  wire logic [15:0]         mem_data_in,
   output logic                     req_ready_reg,
   output logic [15:0]              rdata_reg,
   output logic                     rdata_valid_reg,
   output logic                     timeout_reg,
   output logic [1:0]               chip_select_n,
   output logic                     out_enable_strobe,
   output logic                     write_strobe,
   output logic [15:0]              mem_addr_reg,
   output logic [15:0]              mem_data_out_reg,
   output logic                     mem_data_oe_n,
   output logic                     burst_clock,
   output logic [15:0]              ecc1_reg,
   output logic [39:0]              ecc4_reg
);
   amem_pkg::state_t   state_reg, state_next;
   amem_pkg::request_t req_reg;
   amem_pkg::timing_t  tm_reg;
   amem_pkg::mode_t    mode_reg;
   logic [1:0] div_reg;
   logic       tick;
   logic [5:0] cnt_reg;
   logic [3:0] unit_reg;
   logic [7:0] counted_wait_cycles_reg;
   logic       wait_seen_reg;
   logic [3:0] words_reg;
   logic [1:0] wait_sync_reg;
   logic [15:0] din_s1_reg, din_s2_reg;
   logic [5:0] phase_last;
   logic       phase_done, unit_end, timeout_hit, burst_ok, sel_low, strobe_low, word_done;
   logic       take, cs_eff, wr_eff, ss_eff;

   // quarter-rate phase enable
   always_ff @(posedge mclk) begin
      if (rst) div_reg <= 2'h0;
      else     div_reg <= div_reg + 2'h1;
   end
   assign tick = (div_reg == amem_pkg::TICK_LAST);

   // pin inputs pass two flops first
   always_ff @(posedge mclk) begin
      if (rst) begin
         wait_sync_reg <= 2'h0;
         din_s1_reg    <= 16'h0000;
         din_s2_reg    <= 16'h0000;
      end else begin
         wait_sync_reg <= {wait_sync_reg[0], ext_wait_in};
         din_s1_reg    <= mem_data_in;
         din_s2_reg    <= din_s1_reg;
      end
   end

   // the accepting edge already drives setup pins, before req_reg and mode_reg load
   assign take   = (state_reg == amem_pkg::ST_IDLE) && req_valid && req_ready_reg;
   assign cs_eff = take ? req.cs : req_reg.cs;
   assign wr_eff = take ? req.write : req_reg.write;
   assign ss_eff = take ? mode.select_strobe_mode : mode_reg.select_strobe_mode;

   // per-chip-select timing, taken at acceptance so a mid-access change is harmless
   always_ff @(posedge mclk) begin
      if (rst) begin
         req_reg  <= '0;
         tm_reg   <= '0;
         mode_reg <= '0;
      end else if (take) begin
         req_reg  <= req;
         tm_reg   <= req.cs ? timing_cs1 : timing_cs0;
         mode_reg <= mode;
      end
   end

   // linear burst only when the bus is 16 bits wide
   assign burst_ok = req_reg.burst && !req_reg.write && mode_reg.burst_nand_mode
                     && mode_reg.bus_16bit;

   // field widths bound every length: 1-16, 1-64, 1-8, 1-4
   always_comb begin
      phase_last = 6'h00;
      unique case (state_reg)
         amem_pkg::ST_SETUP:  phase_last = {2'h0, req_reg.write ? tm_reg.write_setup_cycles
                                                               : tm_reg.read_setup_cycles};
         amem_pkg::ST_STROBE: phase_last = req_reg.write ? tm_reg.write_strobe_cycles
                                                         : tm_reg.read_strobe_cycles;
         amem_pkg::ST_HOLD:   phase_last = {3'h0, req_reg.write ? tm_reg.write_hold_cycles
                                                               : tm_reg.read_hold_cycles};
         amem_pkg::ST_TURN:   phase_last = {4'h0, tm_reg.turnaround_cycles};
         default:             phase_last = 6'h00;
      endcase
   end
   assign phase_done  = tick && (cnt_reg == phase_last);
   assign unit_end    = tick && (unit_reg == amem_pkg::WAIT_UNIT_LAST);
   assign timeout_hit = unit_end && wait_seen_reg
                        && (counted_wait_cycles_reg == mode_reg.maximum_wait_cycles);
   assign word_done   = tick && burst_clock;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         amem_pkg::ST_IDLE:
            if (req_valid && req_ready_reg) state_next = amem_pkg::ST_SETUP;
         amem_pkg::ST_SETUP:
            if (phase_done) state_next = burst_ok ? amem_pkg::ST_BURST : amem_pkg::ST_STROBE;
         amem_pkg::ST_STROBE:
            if (phase_done) begin
               // the memory had to raise wait two mclk cycles ahead of this edge
               if (mode_reg.extended_wait_enable && wait_sync_reg[1]) state_next = amem_pkg::ST_WAIT;
               else                                                  state_next = amem_pkg::ST_HOLD;
            end
         amem_pkg::ST_WAIT:
            if (unit_end && (!wait_seen_reg || timeout_hit)) state_next = amem_pkg::ST_HOLD;
         amem_pkg::ST_BURST:
            if (word_done && words_reg == req_reg.burst_len) state_next = amem_pkg::ST_HOLD;
         amem_pkg::ST_HOLD:
            if (phase_done) state_next = amem_pkg::ST_TURN;
         amem_pkg::ST_TURN:
            if (phase_done) state_next = amem_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) state_reg <= amem_pkg::ST_IDLE;
      else     state_reg <= state_next;
   end

   always_ff @(posedge mclk) begin
      if (rst || state_next != state_reg) cnt_reg <= 6'h00;
      else if (tick)                      cnt_reg <= cnt_reg + 6'h01;
   end

   // wait units: sample the wait level four periods before each unit ends
   always_ff @(posedge mclk) begin
      if (rst || state_reg != amem_pkg::ST_WAIT) begin
         unit_reg                <= 4'h0;
         counted_wait_cycles_reg <= 8'h00;
         wait_seen_reg           <= 1'b1;
      end else if (tick) begin
         unit_reg <= unit_reg + 4'h1;
         if (unit_reg == amem_pkg::WAIT_CHECK_TICK) wait_seen_reg <= wait_sync_reg[1];
         if (unit_end) counted_wait_cycles_reg <= counted_wait_cycles_reg + 8'h01;
      end
   end

   // pin outputs follow the next state so they line up with it
   assign strobe_low = (state_next == amem_pkg::ST_STROBE) || (state_next == amem_pkg::ST_WAIT)
                       || (state_next == amem_pkg::ST_BURST);
   assign sel_low    = ss_eff ? strobe_low
                       : (state_next == amem_pkg::ST_SETUP || strobe_low
                          || state_next == amem_pkg::ST_HOLD);

   always_ff @(posedge mclk) begin
      if (rst) begin
         chip_select_n     <= 2'b11;
         out_enable_strobe <= 1'b1;
         write_strobe      <= 1'b1;
         mem_data_oe_n     <= 1'b1;
         req_ready_reg     <= 1'b0;
      end else begin
         chip_select_n     <= sel_low ? (cs_eff ? 2'b01 : 2'b10) : 2'b11;
         out_enable_strobe <= !(strobe_low && !req_reg.write);
         write_strobe      <= !(strobe_low && req_reg.write);
         mem_data_oe_n     <= !(wr_eff && sel_low);
         req_ready_reg     <= (state_next == amem_pkg::ST_IDLE);
      end
   end

   // 8-bit bus addresses bytes, 16-bit bus addresses words
   always_ff @(posedge mclk) begin
      if (rst) begin
         mem_addr_reg     <= 16'h0000;
         mem_data_out_reg <= 16'h0000;
      end else if (state_reg == amem_pkg::ST_SETUP && cnt_reg == 6'h00) begin
         mem_addr_reg     <= mode_reg.bus_16bit ? {1'b0, req_reg.addr[15:1]} : req_reg.addr;
         mem_data_out_reg <= mode_reg.bus_16bit ? req_reg.wdata : {8'h00, req_reg.wdata[7:0]};
      end
   end

   // burst clock toggles once per phase period
   always_ff @(posedge mclk) begin
      if (rst || state_reg != amem_pkg::ST_BURST) begin
         burst_clock <= 1'b0;
         words_reg   <= amem_pkg::BURST_LEN_RESET;
      end else if (tick) begin
         burst_clock <= !burst_clock;
         if (burst_clock) words_reg <= words_reg + 4'h1;
      end
   end

   // read data taken from the synchronised bus at strobe end or burst clock fall
   logic read_take;
   assign read_take = (!req_reg.write && state_reg == amem_pkg::ST_STROBE && state_next == amem_pkg::ST_HOLD)
                      || (state_reg == amem_pkg::ST_WAIT && state_next == amem_pkg::ST_HOLD
                          && !req_reg.write)
                      || (state_reg == amem_pkg::ST_BURST && word_done);
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_reg       <= 16'h0000;
         rdata_valid_reg <= 1'b0;
         timeout_reg     <= 1'b0;
      end else begin
         rdata_valid_reg <= read_take;
         timeout_reg     <= timeout_hit && state_reg == amem_pkg::ST_WAIT;
         if (read_take) rdata_reg <= mode_reg.bus_16bit ? din_s2_reg : {8'h00, din_s2_reg[7:0]};
      end
   end

   logic ecc_take;
   assign ecc_take = mode_reg.nand_mode && ((req_reg.write && state_reg == amem_pkg::ST_STROBE
                     && phase_done) || read_take);
   amem_ecc u_ecc (
      .mclk     (mclk),
      .rst      (rst),
      .clear    (ecc_clear),
      .valid    (ecc_take),
      .data     (req_reg.write ? req_reg.wdata : din_s2_reg),
      .ecc1_reg (ecc1_reg),
      .ecc4_reg (ecc4_reg)
   );

   chk_tick_rate: assert property (@(posedge mclk) disable iff (rst) tick |=> !tick [*3])
      else $error("phase enable not quarter rate");
   chk_cs_before_oe: assert property (@(posedge mclk) disable iff (rst)
      $fell(out_enable_strobe) |-> chip_select_n != 2'b11)
      else $error("strobe fell without select");
   chk_ss_together: assert property (@(posedge mclk) disable iff (rst)
      mode_reg.select_strobe_mode && !req_reg.write |-> (chip_select_n != 2'b11) == !out_enable_strobe)
      else $error("select strobe mode misaligned");
   chk_hold_to_turn: assert property (@(posedge mclk) disable iff (rst)
      state_reg == amem_pkg::ST_HOLD && state_next != amem_pkg::ST_HOLD |=> state_reg == amem_pkg::ST_TURN)
      else $error("no turnaround after hold");
   chk_phase_bound: assert property (@(posedge mclk) disable iff (rst)
      state_reg inside {amem_pkg::ST_SETUP, amem_pkg::ST_HOLD, amem_pkg::ST_TURN} |-> cnt_reg <= phase_last)
      else $error("phase ran past its length");
   chk_timeout_hold: assert property (@(posedge mclk) disable iff (rst)
      timeout_reg |-> state_reg == amem_pkg::ST_HOLD && out_enable_strobe && write_strobe)
      else $error("timeout did not end strobe");
   // four more ticks close the unit; the state register shows hold one edge later
   chk_wait_release: assert property (@(posedge mclk) disable iff (rst)
      state_reg == amem_pkg::ST_WAIT && tick && unit_reg == amem_pkg::WAIT_CHECK_TICK
      && !wait_sync_reg[1] |-> ##16 (state_reg == amem_pkg::ST_WAIT && unit_end)
      ##1 state_reg == amem_pkg::ST_HOLD)
      else $error("strobe release not four periods after wait");
   chk_burst_width: assert property (@(posedge mclk) disable iff (rst)
      state_reg == amem_pkg::ST_BURST |-> mode_reg.bus_16bit && !req_reg.write)
      else $error("burst on narrow bus");
   chk_burst_clk: assert property (@(posedge mclk) disable iff (rst)
      $changed(burst_clock) && state_reg == amem_pkg::ST_BURST |-> $past(tick))
      else $error("burst clock off rate");
   chk_wait_order: assert property (@(posedge mclk) disable iff (rst)
      $rose(state_reg == amem_pkg::ST_HOLD) |-> $past(state_reg) inside {amem_pkg::ST_STROBE,
      amem_pkg::ST_WAIT, amem_pkg::ST_BURST})
      else $error("hold entered out of order");
   cov_read: cover property (@(posedge mclk) $rose(rdata_valid_reg) && !req_reg.write);
   cov_write: cover property (@(posedge mclk) $fell(write_strobe));
   cov_timeout: cover property (@(posedge mclk) timeout_reg);
   cov_burst: cover property (@(posedge mclk) state_reg == amem_pkg::ST_BURST && word_done);
endmodule : amem_ctrl

// >>> testbench/mem_model.sv
// behavioural asynchronous sram on the memory pins, with a scripted wait line
// assumes one chip holds both selects; only the low address byte is decoded
`timescale 1ns/10ps
module mem_model (
   input  wire logic        mclk,
   input  wire logic [1:0]  chip_select_n,
   input  wire logic        out_enable_strobe,
   input  wire logic        write_strobe,
   input  wire logic [15:0] addr,
   input  wire logic [15:0] wdata,
   input  wire logic [15:0] wait_len,
   output logic             ext_wait_in,
   output logic [15:0]      mem_data_in
);
   logic [15:0] mem [0:255];
   logic [15:0] last_q;
   logic [15:0] wait_cnt;
   logic        strb_q;
   logic        we_q;
   logic        drive;

   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 16'(i);
      end
      last_q   = 16'h0000;
      wait_cnt = 16'h0000;
      strb_q   = 1'b1;
      we_q     = 1'b1;
   end

   assign drive = ~&chip_select_n & ~out_enable_strobe;
   // released bus shows the inverse of the last value, never a stale copy
   assign mem_data_in = drive ? mem[addr[7:0]] : ~last_q;
   assign ext_wait_in = (wait_cnt != 16'h0000);

   always @(posedge mclk) begin
      strb_q <= out_enable_strobe & write_strobe;
      we_q   <= write_strobe;
      if (drive) begin
         last_q <= mem[addr[7:0]];
      end
      // store on the rising write strobe; the select may rise on the same edge
      if (!we_q && write_strobe) begin
         mem[addr[7:0]] <= wdata;
      end
   end

   // wait raised one cycle after strobe falls, far ahead of strobe end
   always @(posedge mclk) begin
      if (strb_q && !(out_enable_strobe & write_strobe)) begin
         wait_cnt <= wait_len;
      end else if (!strb_q && (out_enable_strobe & write_strobe)) begin
         wait_cnt <= 16'h0000;
      end else if (wait_cnt != 16'h0000) begin
         wait_cnt <= wait_cnt - 16'h0001;
      end
   end
endmodule : mem_model

// >>> testbench/amem_ctrl_tb.sv
// self-checking bench for the asynchronous memory controller
// assumes amem_ctrl is the device under test and mem_model answers its pins
`timescale 1ns/10ps
module amem_ctrl_tb;
   localparam int LIMIT = 20000;
   logic               mclk       = 1'b0;
   logic               rst        = 1'b1;
   logic               req_valid  = 1'b0;
   amem_pkg::request_t req        = '0;
   amem_pkg::timing_t  timing_cs0 = '{2'h1, 4'h2, 6'h07, 3'h1, 4'h3, 6'h04, 3'h2};
   amem_pkg::timing_t  timing_cs1 = '{2'h3, 4'hF, 6'h3F, 3'h7, 4'h1, 6'h05, 3'h4};
   amem_pkg::mode_t    mode       = '0;
   logic               ecc_clear  = 1'b0;
   logic [15:0]        wait_len   = 16'h0000;
   logic               ext_wait_in, req_ready_reg, rdata_valid_reg, timeout_reg;
   logic               out_enable_strobe, write_strobe, mem_data_oe_n, burst_clock;
   logic [15:0]        mem_data_in, rdata_reg, mem_addr_reg, mem_data_out_reg, ecc1_reg, rd_last;
   logic [1:0]         chip_select_n, cs_seen;
   logic [39:0]        ecc4_reg;
   logic               cs_q = 1'b1;
   logic               st_q = 1'b1;
   logic               oe_seen = 1'b1;
   int                 cyc, t_csf, t_csr, t_stf, t_str, gap, rd_cnt, to_cnt, bc_run, bc_hi, n0;
   int                 error_cnt, comparisons;

   always #12.5 mclk = ~mclk;

   amem_ctrl i_amem_ctrl (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req), .timing_cs0(timing_cs0),
      .timing_cs1(timing_cs1), .mode(mode), .ecc_clear(ecc_clear), .ext_wait_in(ext_wait_in),
      .mem_data_in(mem_data_in), .req_ready_reg(req_ready_reg), .rdata_reg(rdata_reg),
      .rdata_valid_reg(rdata_valid_reg), .timeout_reg(timeout_reg), .chip_select_n(chip_select_n),
      .out_enable_strobe(out_enable_strobe), .write_strobe(write_strobe), .mem_addr_reg(mem_addr_reg),
      .mem_data_out_reg(mem_data_out_reg), .mem_data_oe_n(mem_data_oe_n), .burst_clock(burst_clock),
      .ecc1_reg(ecc1_reg), .ecc4_reg(ecc4_reg));

   mem_model i_mem_model (.mclk(mclk), .chip_select_n(chip_select_n), .out_enable_strobe(out_enable_strobe),
      .write_strobe(write_strobe), .addr(mem_addr_reg), .wdata(mem_data_out_reg), .wait_len(wait_len),
      .ext_wait_in(ext_wait_in), .mem_data_in(mem_data_in));

   // edge times of select and strobe, counted in mclk cycles
   always @(posedge mclk) begin
      cyc  <= cyc + 1;
      cs_q <= &chip_select_n;
      st_q <= out_enable_strobe & write_strobe;
      if (cs_q && !(&chip_select_n)) begin
         t_csf   <= cyc;
         gap     <= cyc - t_csr;
         cs_seen <= chip_select_n;
      end
      if (!cs_q && (&chip_select_n)) begin
         t_csr <= cyc;
      end
      if (st_q && !(out_enable_strobe & write_strobe)) begin
         t_stf   <= cyc;
         oe_seen <= mem_data_oe_n;
      end
      if (!st_q && (out_enable_strobe & write_strobe)) begin
         t_str <= cyc;
      end
      if (rdata_valid_reg === 1'b1) begin
         rd_cnt  <= rd_cnt + 1;
         rd_last <= rdata_reg;
      end
      if (timeout_reg === 1'b1) begin
         to_cnt <= to_cnt + 1;
      end
      if (burst_clock === 1'b1) begin
         bc_run <= bc_run + 1;
      end else begin
         if (bc_run != 0) begin
            bc_hi <= bc_run;
         end
         bc_run <= 0;
      end
   end

   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic access(input logic w, input logic c, input logic b, input logic [3:0] n,
                         input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk);
      req_valid <= 1'b1;
      req       <= '{w, c, b, n, a, d};
      do @(posedge mclk); while (req_ready_reg !== 1'b1);
      req_valid <= 1'b0;
   endtask : access

   task automatic wait_idle;
      @(posedge mclk);
      while (req_ready_reg !== 1'b1) @(posedge mclk);
   endtask : wait_idle

   task automatic set_mode(input logic b16, input logic ss, input logic ew, input logic nd, input logic bn);
      @(posedge mclk);
      mode <= '{b16, ss, ew, nd, bn, 8'h01};
   endtask : set_mode

   // lengths in phase periods; setup loses up to one period to enable alignment
   task automatic phases(input int s, input int w, input int h);
      check("setup", (t_stf - t_csf <= s * 4) && (t_stf - t_csf + 4 > s * 4), 1'b1);
      check("strobe width", t_str - t_stf, w * 4);
      check("hold", t_csr - t_str, h * 4);
   endtask : phases

   task automatic report_and_stop;
      if (error_cnt == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (LIMIT) @(posedge mclk);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      set_mode(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      access(1'b1, 1'b0, 1'b0, 4'h0, 16'h0010, 16'hA55A);
      wait_idle();
      phases(4, 5, 3);
      check("select", cs_seen, 2'b10);
      check("data drive", oe_seen, 1'b0);
      access(1'b0, 1'b0, 1'b0, 4'h0, 16'h0010, 16'h0000);
      wait_idle();
      phases(3, 8, 2);
      check("read data", rd_last, 16'hA55A);
      check("data drive", oe_seen, 1'b1);
      // back to back on the top address, every read phase at its longest
      access(1'b1, 1'b1, 1'b0, 4'h0, 16'hFFFE, 16'h3C3C);
      access(1'b0, 1'b1, 1'b0, 4'h0, 16'hFFFE, 16'h0000);
      wait_idle();
      check("turnaround", gap >= 16, 1'b1);
      phases(16, 64, 8);
      check("select", cs_seen, 2'b01);
      check("read data", rd_last, 16'h3C3C);
      check("address", mem_addr_reg, 16'h7FFF);
      set_mode(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      access(1'b0, 1'b0, 1'b0, 4'h0, 16'h0010, 16'h0000);
      wait_idle();
      phases(0, 8, 0);
      set_mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      access(1'b1, 1'b0, 1'b0, 4'h0, 16'h0005, 16'h00C3);
      access(1'b0, 1'b0, 1'b0, 4'h0, 16'h0005, 16'h0000);
      wait_idle();
      check("byte data", rd_last[7:0], 8'hC3);
      set_mode(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      wait_len <= 16'h0028;
      n0 = to_cnt;
      access(1'b0, 1'b0, 1'b0, 4'h0, 16'h0010, 16'h0000);
      wait_idle();
      check("wait strobe", t_str - t_stf, 32 + 64);
      check("no timeout", to_cnt, n0);
      wait_len <= 16'h03E8;
      access(1'b0, 1'b0, 1'b0, 4'h0, 16'h0010, 16'h0000);
      wait_idle();
      check("timeout strobe", t_str - t_stf, 32 + 128);
      check("timeout", to_cnt, n0 + 1);
      check("hold", t_csr - t_str, 8);
      wait_len <= 16'h0000;
      set_mode(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      n0 = rd_cnt;
      access(1'b0, 1'b0, 1'b1, 4'h3, 16'h0020, 16'h0000);
      wait_idle();
      check("burst words", rd_cnt - n0, 4);
      check("burst clock", bc_hi, 4);
      // byte bus: a burst request falls back to one plain read
      set_mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      n0 = rd_cnt;
      access(1'b0, 1'b0, 1'b1, 4'h3, 16'h0020, 16'h0000);
      wait_idle();
      check("fallback words", rd_cnt - n0, 1);
      set_mode(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      ecc_clear <= 1'b1;
      @(posedge mclk);
      ecc_clear <= 1'b0;
      access(1'b1, 1'b0, 1'b0, 4'h0, 16'h0030, 16'h1234);
      access(1'b1, 1'b1, 1'b0, 4'h0, 16'h0030, 16'h0F0F);
      wait_idle();
      check("ecc parity", ecc1_reg, 16'h1D3B);
      check("ecc syndromes", ecc4_reg, {10'h331, 10'h34B, 10'h377, 10'h365});
      report_and_stop();
   end
endmodule : amem_ctrl_tb
